// ---- gstm_consts.vh ----
// constants for the gated sixteen-bit timer: register map, fields, reset values
// Notes on behaviour
// - counter is sixteen bits, high and low bytes
// - byte write loads counter byte at once
// - instruction clock source advances once per cycle
// - external source advances on each selected edge
// - run off stops; run only counts; both gate
// - select 11 lfosc, 10 pin, 01 sys, 00 sys/4
// - every source, the pin included, advances through the prescaler
// - system clock gives four counts per instruction
// - external pin counts on rising edges
// - external pin synchronised or asynchronous, selectable
// - falling edge needed before first counted rise
// - gate source is pin, comparator 1 or 2
`ifndef GSTM_CONSTS_VH
`define GSTM_CONSTS_VH

// apb register byte offsets
`define GSTM_ADDR_W 5
`define GSTM_OFS_COUNT_LOW 5'h00
`define GSTM_OFS_COUNT_HIGH 5'h04
`define GSTM_OFS_TIMER_CONTROL 5'h08
`define GSTM_OFS_GATE_CONTROL 5'h0c
`define GSTM_OFS_STATUS 5'h10

// timer_control fields
`define GSTM_TC_RUN 0
`define GSTM_TC_ASYNC 2
`define GSTM_TC_PS_LO 4
`define GSTM_TC_PS_HI 5
`define GSTM_TC_CS_LO 6
`define GSTM_TC_CS_HI 7
`define GSTM_TC_RESET 8'h00

// gate_control fields
`define GSTM_GC_SRC_LO 0
`define GSTM_GC_SRC_HI 1
`define GSTM_GC_POL 6
`define GSTM_GC_EN 7
`define GSTM_GC_RESET 8'h00

// status fields
`define GSTM_ST_ACTIVE 0
`define GSTM_ST_GATE 1
`define GSTM_ST_ARMED 2
`define GSTM_ST_WRAPPED 3

// clock select codes
`define GSTM_CS_INSTR 2'h0
`define GSTM_CS_SYS 2'h1
`define GSTM_CS_PIN 2'h2
`define GSTM_CS_LFOSC 2'h3

// gate source codes
`define GSTM_GS_PIN 2'h0
`define GSTM_GS_CMP1 2'h1
`define GSTM_GS_CMP2 2'h2

// timing: system clock and instruction cycle
`define GSTM_CLK_HZ 50000000
`define GSTM_SYS_PER_INSTR 4
`define GSTM_INSTR_LAST 2'h3

// misc widths and values
`define GSTM_COUNT_RESET 16'h0000
`define GSTM_COUNT_ONES 16'hffff
`define GSTM_COUNT_ONE 16'h0001
`define GSTM_PRE_ZERO 3'h0
`define GSTM_PRE_ONE 3'h1
`define GSTM_BYTE_ZERO 8'h00
`define GSTM_WORD_ZERO 32'h00000000

`endif

// ---- gstm_pin_sync.v ----
// two-stage synchroniser with edge detection for one asynchronous input
`timescale 1ns/10ps
module gstm_pin_sync (
    input wire clk,         // system clock
    input wire rst,         // synchronous reset, active high
    input wire async_in,    // raw asynchronous input
    output reg level,       // synchronised level
    output reg rise,        // one-cycle pulse on a rising edge
    output reg fall         // one-cycle pulse on a falling edge
);

////////////////////////////////////////////////////////////////////////////////
reg meta;       // first stage, read only by the second stage
reg sync_q;     // second stage
reg prev;       // delayed copy for edge detection

// synchroniser chain; edges are judged on the second stage only
always @(posedge clk) begin
    if (rst) begin
        meta <= 1'b0;
        sync_q <= 1'b0;
        prev <= 1'b0;
        level <= 1'b0;
        rise <= 1'b0;
        fall <= 1'b0;
    end else begin
        meta <= async_in;
        sync_q <= meta;
        prev <= sync_q;
        level <= sync_q;
        rise <= sync_q & ~prev;
        fall <= ~sync_q & prev;
    end
end

endmodule

// ---- gstm_src_model.sv ----
// source model for the timer pins: count clock, gate, comparators, slow oscillator
`timescale 1ns/10ps
module gstm_src_model (
    input wire clk, // system clock
    input wire rst, // reset, restarts the slow oscillator
    output reg ext_count_pin, // external count clock
    output reg gate_pin, // dedicated gate pin
    output reg cmp1_out, // comparator 1 output
    output reg cmp2_out, // comparator 2 output
    output reg low_freq_internal_osc // free-running slow oscillator
);
    reg [3:0] lf_cnt; // half-period counter of the slow oscillator
    initial begin
        {ext_count_pin, gate_pin, cmp1_out, cmp2_out, low_freq_internal_osc} = 5'h00;
        lf_cnt = 4'h0;
    end
    ////////////////////////////////////////
    // slow oscillator runs free, period of twenty system clocks
    always @(posedge clk) begin
        if (rst) begin
            lf_cnt <= 4'h0;
            low_freq_internal_osc <= 1'b0;
        end else if (lf_cnt == 4'h9) begin
            lf_cnt <= 4'h0;
            low_freq_internal_osc <= ~low_freq_internal_osc;
        end else begin
            lf_cnt <= lf_cnt + 4'h1;
        end
    end
    // gate sources: bit 0 pin, bit 1 comparator 1, bit 2 comparator 2
    task set_gates(input [2:0] g);
        {cmp2_out, cmp1_out, gate_pin} <= g;
    endtask
    // drive the count pin and hold it; a short hold is a prompt source
    task pin_level(input v, input integer hold);
        begin
            ext_count_pin <= v;
            repeat (hold) @(posedge clk);
        end
    endtask
endmodule

// ---- gstm_timer.v ----
// gated sixteen-bit timer with apb register access
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/10ps
`include "gstm_consts.vh"
module gstm_timer (
    input wire clk,                    // system clock, 50 MHz
    input wire rst,                    // synchronous reset, active high
    input wire psel,                   // apb select
    input wire penable,                // apb access phase
    input wire pwrite,                 // apb direction, high for write
    input wire [31:0] paddr,           // apb byte address
    input wire [31:0] pwdata,          // apb write data
    output reg [31:0] prdata,          // apb read data
    output reg pready,                 // apb ready
    output reg pslverr,                // apb error on unmapped address
    input wire ext_count_pin,          // external count clock pin
    input wire gate_pin,               // dedicated gate pin
    input wire cmp1_out,               // comparator 1 output
    input wire cmp2_out,               // comparator 2 output
    input wire low_freq_internal_osc,  // low-frequency oscillator clock
    output reg wrap_pulse              // one-cycle pulse when the counter wraps
);

////////////////////////////////////////////////////////////////////////////////
// state and configuration

reg [7:0] count_low_byte;     // counter low byte
reg [7:0] count_high_byte;    // counter high byte
reg [7:0] timer_control;      // run, async, prescale, clock select
reg [7:0] gate_control;       // gate enable, polarity, source
reg [1:0] instr_div;          // divides the system clock by four
reg instr_tick;               // one pulse per instruction cycle
reg [2:0] pre_cnt;            // prescaler counter
reg armed;                    // falling edge seen since last disarm
reg ext_pending;              // synchronised-mode edge awaiting instruction tick
reg wrapped;                  // sticky copy of last wrap, cleared by a counter write, for status

wire ext_rise;                // rising edge of external pin
wire ext_fall;                // falling edge of external pin
wire gate_pin_level;          // synchronised gate pin
wire cmp1_level;              // synchronised comparator 1
wire cmp2_level;              // synchronised comparator 2
wire lfosc_rise;              // rising edge of low-frequency oscillator

wire run_enable;              // counter run bit
wire gate_enable;             // gate enable bit
wire async_mode;              // external pin counts without instruction alignment
wire [1:0] clock_select;      // clock source select
wire [1:0] prescale;          // prescaler ratio code
wire gate_polarity;           // gate active level
wire [1:0] gate_source;       // gate source select

////////////////////////////////////////////////////////////////////////////////
// input synchronisers

gstm_pin_sync gstm_sync_ext (
    .clk(clk),
    .rst(rst),
    .async_in(ext_count_pin),
    .level(),
    .rise(ext_rise),
    .fall(ext_fall)
);

gstm_pin_sync gstm_sync_gate (
    .clk(clk),
    .rst(rst),
    .async_in(gate_pin),
    .level(gate_pin_level),
    .rise(),
    .fall()
);

gstm_pin_sync gstm_sync_cmp1 (
    .clk(clk),
    .rst(rst),
    .async_in(cmp1_out),
    .level(cmp1_level),
    .rise(),
    .fall()
);

gstm_pin_sync gstm_sync_cmp2 (
    .clk(clk),
    .rst(rst),
    .async_in(cmp2_out),
    .level(cmp2_level),
    .rise(),
    .fall()
);

gstm_pin_sync gstm_sync_lfosc (
    .clk(clk),
    .rst(rst),
    .async_in(low_freq_internal_osc),
    .level(),
    .rise(lfosc_rise),
    .fall()
);

////////////////////////////////////////////////////////////////////////////////
// field decode

assign run_enable = timer_control[`GSTM_TC_RUN];
assign async_mode = timer_control[`GSTM_TC_ASYNC];
assign prescale = timer_control[`GSTM_TC_PS_HI:`GSTM_TC_PS_LO];
assign clock_select = timer_control[`GSTM_TC_CS_HI:`GSTM_TC_CS_LO];
assign gate_enable = gate_control[`GSTM_GC_EN];
assign gate_polarity = gate_control[`GSTM_GC_POL];
assign gate_source = gate_control[`GSTM_GC_SRC_HI:`GSTM_GC_SRC_LO];

// true when the byte address selects the given register offset
function addr_hit;
    input [31:0] addr;
    input [`GSTM_ADDR_W-1:0] ofs;
    begin
        addr_hit = (addr[31:`GSTM_ADDR_W] == 27'h0000000) && (addr[`GSTM_ADDR_W-1:0] == ofs);
    end
endfunction

// last prescaler count for a ratio of 1, 2, 4 or 8
function [2:0] pre_last;
    input [1:0] code;
    begin
        pre_last = (`GSTM_PRE_ONE << code) - `GSTM_PRE_ONE;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// bus decode

wire bus_access = psel & penable & pready;                // completing transfer
wire bus_write = bus_access & pwrite;                      // write takes effect
wire wr_low = bus_write & addr_hit(paddr, `GSTM_OFS_COUNT_LOW);
wire wr_high = bus_write & addr_hit(paddr, `GSTM_OFS_COUNT_HIGH);
wire wr_tc = bus_write & addr_hit(paddr, `GSTM_OFS_TIMER_CONTROL);
wire wr_gc = bus_write & addr_hit(paddr, `GSTM_OFS_GATE_CONTROL);
wire count_write = wr_low | wr_high;                       // any counter byte write

////////////////////////////////////////////////////////////////////////////////
// gate and source selection

reg gate_raw;                 // selected gate source level
reg src_tick;                 // selected clock source event

// pick the gate source
always @* begin
    case (gate_source)
        `GSTM_GS_PIN: gate_raw = gate_pin_level;
        `GSTM_GS_CMP1: gate_raw = cmp1_level;
        `GSTM_GS_CMP2: gate_raw = cmp2_level;
        default: gate_raw = gate_pin_level;
    endcase
end

wire gate_active = (gate_raw == gate_polarity);   // gate at its active level

// counting allowed by run and gate bits
wire count_en = run_enable & (~gate_enable | gate_active);

// synchronised-mode external edge lands on the instruction tick
wire ext_event = async_mode ? (ext_rise & armed) : ((ext_rise & armed) | ext_pending);

// pick the clock source event
always @* begin
    case (clock_select)
        `GSTM_CS_INSTR: src_tick = instr_tick;
        `GSTM_CS_SYS: src_tick = 1'b1;
        `GSTM_CS_PIN: src_tick = async_mode ? ext_event : (ext_event & instr_tick);
        `GSTM_CS_LFOSC: src_tick = lfosc_rise;
        default: src_tick = 1'b0;
    endcase
end

wire pin_mode = (clock_select == `GSTM_CS_PIN);       // counter mode
wire pre_done = (pre_cnt == pre_last(prescale));       // prescaler reaches its ratio
wire advance = count_en & src_tick & pre_done & ~count_write;
wire at_ones = ({count_high_byte, count_low_byte} == `GSTM_COUNT_ONES);

////////////////////////////////////////////////////////////////////////////////
// instruction cycle divider

// one pulse every fourth system clock
always @(posedge clk) begin
    if (rst) begin
        instr_div <= 2'h0;
        instr_tick <= 1'b0;
    end else begin
        instr_div <= instr_div + 2'h1;
        instr_tick <= (instr_div == `GSTM_INSTR_LAST);
    end
end

////////////////////////////////////////////////////////////////////////////////
// falling-edge arming for counter mode

// disarm on disable or counter write; a falling edge while running arms,
// and it wins over a counter write in the same cycle
always @(posedge clk) begin
    if (rst) begin
        armed <= 1'b0;
    end else if (~run_enable) begin
        armed <= 1'b0;
    end else if (ext_fall) begin
        armed <= 1'b1;
    end else if (count_write) begin
        armed <= 1'b0;
    end
end

// hold a synchronised-mode edge until the next instruction tick
always @(posedge clk) begin
    if (rst) begin
        ext_pending <= 1'b0;
    end else if (~run_enable | count_write | async_mode | ~pin_mode) begin
        ext_pending <= 1'b0;
    end else if (instr_tick) begin
        ext_pending <= 1'b0;
    end else if (ext_rise & armed) begin
        ext_pending <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// prescaler

// count source events; restart on counter write or when off
always @(posedge clk) begin
    if (rst) begin
        pre_cnt <= `GSTM_PRE_ZERO;
    end else if (count_write | ~run_enable) begin
        pre_cnt <= `GSTM_PRE_ZERO;
    end else if (count_en & src_tick) begin
        if (pre_done) begin
            pre_cnt <= `GSTM_PRE_ZERO;
        end else begin
            pre_cnt <= pre_cnt + `GSTM_PRE_ONE;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// counter

// byte writes load at once and win over an advance
always @(posedge clk) begin
    if (rst) begin
        count_low_byte <= `GSTM_BYTE_ZERO;
        count_high_byte <= `GSTM_BYTE_ZERO;
        wrap_pulse <= 1'b0;
        wrapped <= 1'b0;
    end else begin
        wrap_pulse <= advance & at_ones;
        if (count_write) begin
            wrapped <= 1'b0;
            if (wr_low) begin
                count_low_byte <= pwdata[7:0];
            end
            if (wr_high) begin
                count_high_byte <= pwdata[7:0];
            end
        end else if (advance) begin
            // sixteen-bit increment rolls from all ones to zero
            {count_high_byte, count_low_byte} <= {count_high_byte, count_low_byte} + `GSTM_COUNT_ONE;
            if (at_ones) begin
                wrapped <= 1'b1;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// control registers

// software-written configuration
always @(posedge clk) begin
    if (rst) begin
        timer_control <= `GSTM_TC_RESET;
        gate_control <= `GSTM_GC_RESET;
    end else begin
        if (wr_tc) begin
            timer_control <= pwdata[7:0];
        end
        if (wr_gc) begin
            gate_control <= pwdata[7:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// apb answer: one wait state, registered outputs

reg [31:0] next_prdata;       // read value for the current address
reg next_err;                 // address is unmapped

// read mux and address check
always @* begin
    next_prdata = `GSTM_WORD_ZERO;
    next_err = 1'b0;
    if (addr_hit(paddr, `GSTM_OFS_COUNT_LOW)) begin
        next_prdata[7:0] = count_low_byte;
    end else if (addr_hit(paddr, `GSTM_OFS_COUNT_HIGH)) begin
        next_prdata[7:0] = count_high_byte;
    end else if (addr_hit(paddr, `GSTM_OFS_TIMER_CONTROL)) begin
        next_prdata[7:0] = timer_control;
    end else if (addr_hit(paddr, `GSTM_OFS_GATE_CONTROL)) begin
        next_prdata[7:0] = gate_control;
    end else if (addr_hit(paddr, `GSTM_OFS_STATUS)) begin
        next_prdata[`GSTM_ST_ACTIVE] = count_en;
        next_prdata[`GSTM_ST_GATE] = gate_active;
        next_prdata[`GSTM_ST_ARMED] = armed;
        next_prdata[`GSTM_ST_WRAPPED] = wrapped;
    end else begin
        next_err = 1'b1;
    end
end

// ready rises in the second access cycle and falls after completion
always @(posedge clk) begin
    if (rst) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= `GSTM_WORD_ZERO;
    end else if (psel & penable & ~pready) begin
        pready <= 1'b1;
        pslverr <= next_err;
        prdata <= pwrite ? `GSTM_WORD_ZERO : next_prdata;
    end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
    end
end

endmodule

// ---- gstm_timer_props.sv ----
// port checker for the gated sixteen-bit timer
`timescale 1ns/10ps
module gstm_timer_props (
    input wire clk, // system clock
    input wire rst, // synchronous reset
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb direction
    input wire [31:0] paddr, // apb address
    input wire [31:0] prdata, // apb read data
    input wire pready, // apb ready
    input wire pslverr, // apb error
    input wire wrap_pulse // wrap pulse
);
    // address hits one of the five registers
    wire mapped = (paddr[31:5] == 27'h0) && (paddr[1:0] == 2'h0) && (paddr[4:2] <= 3'h4);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    // bus answer timing and decode
    ready_one_wait_a: assert property (psel && penable && $past(psel && !penable) |-> !pready ##1 pready)
        else $error("ready not after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    ready_in_access_a: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("ready outside an access phase");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    map_decode_a: assert property (pready |-> pslverr == !mapped)
        else $error("error flag does not match address decode");
    read_upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    bad_read_zero_a: assert property (pready && !pwrite && pslverr |-> prdata == 32'h00000000)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!pready |-> $stable(prdata))
        else $error("read data changed between reads");
    wrap_single_a: assert property (wrap_pulse |=> !wrap_pulse)
        else $error("wrap pulse longer than one cycle");
    // main scenarios reached
    cover property (pready && pslverr);
    cover property (pready && !pwrite && !pslverr);
    cover property (wrap_pulse);
endmodule
bind gstm_timer gstm_timer_props u_gstm_timer_props (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wrap_pulse(wrap_pulse));

// ---- tb.sv ----
// self-checking bench for the gated sixteen-bit timer
`timescale 1ns/10ps
`include "gstm_consts.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    reg clk = 1'b0; // system clock
    reg rst = 1'b1; // synchronous reset
    reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb controls
    reg [31:0] paddr = 32'h0, pwdata = 32'h0; // apb address and data
    wire [31:0] prdata; // apb read data
    wire pready, pslverr, wrap_pulse; // apb answer and wrap
    wire ext_count_pin, gate_pin, cmp1_out, cmp2_out, low_freq_internal_osc; // pins
    integer failures = 0, total_checks = 0, cyc = 0, stamp = 0, wraps = 0; // bookkeeping
    reg [31:0] rd; // last read data
    reg er; // last error flag
    gstm_timer u_gstm_timer (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_count_pin(ext_count_pin), .gate_pin(gate_pin), .cmp1_out(cmp1_out), .cmp2_out(cmp2_out),
        .low_freq_internal_osc(low_freq_internal_osc), .wrap_pulse(wrap_pulse));
    gstm_src_model u_gstm_src_model (.clk(clk), .rst(rst), .ext_count_pin(ext_count_pin),
        .gate_pin(gate_pin), .cmp1_out(cmp1_out), .cmp2_out(cmp2_out),
        .low_freq_internal_osc(low_freq_internal_osc));
    // clock, cycle stamp and wrap pulse count
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (wrap_pulse === 1'b1) wraps <= wraps + 1;
    end
    ////////////////////////////////////////
    // one apb transfer, held until ready is sampled high
    // no cycle count assumed: only the watchdog ends a wait for ready
    task apb(input [31:0] a, input [31:0] wd, input w);
        begin
            @(posedge clk);
            psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= wd;
            @(posedge clk);
            penable <= 1'b1;
            do @(posedge clk); while (pready !== 1'b1);
            rd = prdata; er = pslverr; stamp = cyc;
            psel <= 1'b0; penable <= 1'b0;
        end
    endtask
    task rd_chk(input [31:0] a, input [31:0] e, input ee);
        begin
            apb(a, 32'h0, 1'b0);
            `CHK(rd, e)
            `CHK(er, ee)
        end
    endtask
    // count advance over a fixed span; div 0 means no counting expected
    task measure(input [7:0] gc, input [7:0] tc, input integer div);
        integer t0;
        reg [7:0] v0, e;
        begin
            apb(`GSTM_OFS_TIMER_CONTROL, 32'h0, 1'b1);
            apb(`GSTM_OFS_GATE_CONTROL, {24'h0, gc}, 1'b1);
            apb(`GSTM_OFS_TIMER_CONTROL, {24'h0, tc}, 1'b1);
            apb(`GSTM_OFS_COUNT_LOW, 32'h0, 1'b0);
            t0 = stamp; v0 = rd[7:0];
            // span of 40 edges is a whole number of periods of every source
            repeat (36) @(posedge clk);
            apb(`GSTM_OFS_COUNT_LOW, 32'h0, 1'b0);
            e = (div == 0) ? 8'h00 : 8'((stamp - t0) / div);
            `CHK(rd[7:0] - v0, e)
        end
    endtask
    ////////////////////////////////////////
    // reset values, unmapped and read-only places
    task t_regs;
        begin
            for (int i = 0; i < 4; i++) rd_chk(4 * i, 32'h0, 1'b0);
            // idle gate pin is low and reset polarity is active low: gate status bit set
            rd_chk(`GSTM_OFS_STATUS, 32'h2, 1'b0);
            rd_chk(32'h14, 32'h0, 1'b1);
            apb(`GSTM_OFS_STATUS, 32'hff, 1'b1);
            `CHK(er, 1'b0)
            rd_chk(`GSTM_OFS_STATUS, 32'h2, 1'b0);
            apb(32'h20, 32'h0, 1'b1);
            `CHK(er, 1'b1)
        end
    endtask
    // byte writes load the counter, upper data bits ignored
    task t_load;
        begin
            apb(`GSTM_OFS_COUNT_LOW, 32'habcdef34, 1'b1);
            apb(`GSTM_OFS_COUNT_HIGH, 32'h12, 1'b1);
            rd_chk(`GSTM_OFS_COUNT_LOW, 32'h34, 1'b0);
            rd_chk(`GSTM_OFS_COUNT_HIGH, 32'h12, 1'b0);
        end
    endtask
    // every internal clock source and every prescale, plus the enable table
    task t_rates;
        begin
            measure(8'h00, 8'h40, 0);
            measure(8'h80, 8'h40, 0);
            measure(8'h00, 8'h41, 1);
            measure(8'h00, 8'h51, 2);
            measure(8'h00, 8'h61, 4);
            measure(8'h00, 8'h71, 8);
            measure(8'h00, 8'h01, 4);
            measure(8'h00, 8'hc1, 20);
        end
    endtask
    // gated counting from each gate source, others driven the opposite way
    task t_gate;
        begin
            for (int s = 0; s < 3; s++) begin
                u_gstm_src_model.set_gates(3'(1 << s));
                measure(8'hc0 | 8'(s), 8'h41, 1);
                u_gstm_src_model.set_gates(~3'(1 << s));
                measure(8'hc0 | 8'(s), 8'h41, 0);
                // active-low polarity: the low source now lets it count
                measure(8'h80 | 8'(s), 8'h41, 1);
            end
        end
    endtask
    // pin counting, synchronised then asynchronous; first rise must not count
    task t_pin;
        begin
            // gate left enabled by the gate scenario must not block pin counting
            apb(`GSTM_OFS_GATE_CONTROL, 32'h0, 1'b1);
            for (int m = 0; m < 2; m++) begin
                apb(`GSTM_OFS_TIMER_CONTROL, 32'h0, 1'b1);
                u_gstm_src_model.pin_level(1'b0, 4);
                apb(`GSTM_OFS_TIMER_CONTROL, (m == 0) ? 32'h81 : 32'h85, 1'b1);
                apb(`GSTM_OFS_COUNT_LOW, 32'h0, 1'b1);
                u_gstm_src_model.pin_level(1'b1, 8);
                u_gstm_src_model.pin_level(1'b0, 8);
                for (int k = 0; k < 3; k++) begin
                    u_gstm_src_model.pin_level(1'b1, 8);
                    u_gstm_src_model.pin_level(1'b0, 3);
                end
                repeat (12) @(posedge clk);
                rd_chk(`GSTM_OFS_COUNT_LOW, 32'h3, 1'b0);
            end
        end
    endtask
    // all-ones wraps to zero with one pulse
    task t_wrap;
        begin
            apb(`GSTM_OFS_TIMER_CONTROL, 32'h0, 1'b1);
            apb(`GSTM_OFS_COUNT_HIGH, 32'hff, 1'b1);
            apb(`GSTM_OFS_COUNT_LOW, 32'hfe, 1'b1);
            wraps = 0;
            apb(`GSTM_OFS_TIMER_CONTROL, 32'h41, 1'b1);
            repeat (20) @(posedge clk);
            `CHK(wraps, 1)
            rd_chk(`GSTM_OFS_COUNT_HIGH, 32'h0, 1'b0);
        end
    endtask
    ////////////////////////////////////////
    // verdict and end of run
    task tally_and_finish;
        begin
            $display("checks %0d failures %0d", total_checks, failures);
            if (failures == 0 && total_checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    // watchdog far beyond the expected run length
    initial begin
        #400000;
        failures++;
        tally_and_finish;
    end
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_load;
        t_rates;
        t_gate;
        t_pin;
        t_wrap;
        tally_and_finish;
    end
endmodule
